// *** pmac_pkg.sv ***
// Package for the peripheral multiply-accumulate block.
// Assumes a 16-bit peripheral bus with byte addresses and a byte-write flag.
package pmac_pkg;
	// ****************************************
	// Register addresses
	// ****************************************
	localparam logic [8:0] ADDR_UNSIGNED_PRODUCT = 9'h130;
	localparam logic [8:0] ADDR_SIGNED_PRODUCT   = 9'h132;
	localparam logic [8:0] ADDR_UNSIGNED_ACCUM   = 9'h134;
	localparam logic [8:0] ADDR_SIGNED_ACCUM     = 9'h136;
	localparam logic [8:0] ADDR_SECOND_OPERAND   = 9'h138;
	localparam logic [8:0] ADDR_RESULT_LOW       = 9'h13a;
	localparam logic [8:0] ADDR_RESULT_HIGH      = 9'h13c;
	localparam logic [8:0] ADDR_RESULT_EXT       = 9'h13e;

	// ****************************************
	// Widths, reset values and timing
	// ****************************************
	localparam int          WORD_W        = 16;
	localparam logic [15:0] WORD_RESET    = 16'h0000;
	localparam logic [15:0] EXT_ALL_ONES  = 16'hffff;
	localparam logic [15:0] EXT_CARRY     = 16'h0001;
	localparam int          LATENCY_CYC   = 3;
	localparam logic [1:0]  LATENCY_LAST  = 2'(LATENCY_CYC - 1);

	// Operation selected by the first-operand address (Gray along usual path)
	typedef enum logic [1:0] {
		PMAC_OP_UMPY = 2'b00,
		PMAC_OP_SMPY = 2'b01,
		PMAC_OP_UMAC = 2'b11,
		PMAC_OP_SMAC = 2'b10
	} pmac_op_t;

	typedef enum logic [1:0] {
		PMAC_ST_IDLE = 2'b00,
		PMAC_ST_BUSY = 2'b01,
		PMAC_ST_DONE = 2'b11
	} pmac_state_t;
endpackage : pmac_pkg

// *** pmac_multiplier.sv ***
// 16x16 multiplier peripheral with four operand-one addresses.
// Assumes synchronous bus strobes on clk_in; reads return in the next cycle.
`timescale 1ns/1ns

// How it works
// - Four first-operand addresses select the operation
// - First-operand write stores, selects, never starts
// - Second-operand write starts the selected operation
// - Completion updates low, high and extension
// - Result ready three cycles after trigger
// - First operand and mode kept for repeats
// - Both operand registers hold 16 bits
// - Low word gets lower 16 result bits
// - Unsigned modes: high word is upper 16
// - Signed multiply: high word two's complement
// - Signed accumulate: high word upper 16 bits
// - Unsigned multiply: extension reads zero
// - Signed modes: extension is extended sign
// - Unsigned accumulate: extension holds the carry
// - No overflow detect; extension shows sign
module pmac_multiplier (
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	input  wire logic [8:0]  addr_in,
	input  wire logic        write_in,
	input  wire logic        read_in,
	input  wire logic        byte_in,
	input  wire logic [15:0] wdata_in,
	output logic      [15:0] rdata_out,
	output logic             busy_out
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [15:0]          first_operand;
		pmac_pkg::pmac_op_t   op;
		logic [15:0]          second_operand;
		logic [15:0]          result_low;
		logic [15:0]          result_high;
		logic [15:0]          result_ext;
		pmac_pkg::pmac_state_t state;
		logic [1:0]           count;
		pmac_pkg::pmac_op_t   run_op;
		logic [15:0]          run_a;
		logic [15:0]          run_b;
		logic [15:0]          rdata;
		logic                 busy;
	} pmac_regs_t;

	pmac_regs_t r;
	pmac_regs_t next_r;

	logic [15:0] wval;
	logic signed [31:0] s_prod;
	logic [31:0] u_prod;
	logic [31:0] prod;
	logic [32:0] u_sum;
	logic [31:0] s_sum;
	logic [31:0] accum;

	// Byte writes zero-extend; software sign-extends for signed modes
	assign wval = byte_in ? {8'h00, wdata_in[7:0]} : wdata_in;

	// ****************************************
	// Datapath
	// ****************************************
	assign u_prod = r.run_a * r.run_b;
	assign s_prod = $signed(r.run_a) * $signed(r.run_b);
	assign accum  = {r.result_high, r.result_low};
	assign prod   = (r.run_op == pmac_pkg::PMAC_OP_SMPY ||
	                 r.run_op == pmac_pkg::PMAC_OP_SMAC) ? s_prod : u_prod;
	assign u_sum  = {1'b0, accum} + {1'b0, u_prod};
	// Wraps silently; sign of the wrapped sum goes to the extension
	assign s_sum  = accum + 32'(s_prod);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		next_r = r;
		next_r.rdata = r.rdata;
		if (write_in) begin
			case (addr_in)
				// Operand and mode stored only; no start
				pmac_pkg::ADDR_UNSIGNED_PRODUCT: begin
					next_r.first_operand = wval;
					next_r.op = pmac_pkg::PMAC_OP_UMPY;
				end
				pmac_pkg::ADDR_SIGNED_PRODUCT: begin
					next_r.first_operand = wval;
					next_r.op = pmac_pkg::PMAC_OP_SMPY;
				end
				pmac_pkg::ADDR_UNSIGNED_ACCUM: begin
					next_r.first_operand = wval;
					next_r.op = pmac_pkg::PMAC_OP_UMAC;
				end
				pmac_pkg::ADDR_SIGNED_ACCUM: begin
					next_r.first_operand = wval;
					next_r.op = pmac_pkg::PMAC_OP_SMAC;
				end
				pmac_pkg::ADDR_SECOND_OPERAND: begin
					// Operand one and mode stay for repeated triggers
					next_r.second_operand = wval;
					next_r.run_a  = r.first_operand;
					next_r.run_b  = wval;
					next_r.run_op = r.op;
					next_r.state  = pmac_pkg::PMAC_ST_BUSY;
					next_r.count  = 2'b00;
				end
				pmac_pkg::ADDR_RESULT_LOW: begin
					next_r.result_low = wval;
				end
				pmac_pkg::ADDR_RESULT_HIGH: begin
					next_r.result_high = wval;
				end
				default: begin
					next_r.state = r.state;
				end
			endcase
		end
		if (r.state == pmac_pkg::PMAC_ST_BUSY &&
		    !(write_in && addr_in == pmac_pkg::ADDR_SECOND_OPERAND)) begin
			if (r.count == pmac_pkg::LATENCY_LAST) begin
				// Results land on the third edge after the trigger
				next_r.state = pmac_pkg::PMAC_ST_DONE;
				next_r.result_low = prod[15:0];
				case (r.run_op)
					pmac_pkg::PMAC_OP_UMPY: begin
						next_r.result_high = u_prod[31:16];
						next_r.result_ext  = pmac_pkg::WORD_RESET;
					end
					pmac_pkg::PMAC_OP_SMPY: begin
						next_r.result_high = s_prod[31:16];
						next_r.result_ext  = s_prod[31] ? pmac_pkg::EXT_ALL_ONES
						                                : pmac_pkg::WORD_RESET;
					end
					pmac_pkg::PMAC_OP_UMAC: begin
						next_r.result_low  = u_sum[15:0];
						next_r.result_high = u_sum[31:16];
						next_r.result_ext  = u_sum[32] ? pmac_pkg::EXT_CARRY
						                               : pmac_pkg::WORD_RESET;
					end
					default: begin
						next_r.result_low  = s_sum[15:0];
						next_r.result_high = s_sum[31:16];
						next_r.result_ext  = s_sum[31] ? pmac_pkg::EXT_ALL_ONES
						                               : pmac_pkg::WORD_RESET;
					end
				endcase
			end else begin
				next_r.count = r.count + 2'b01;
			end
		end else if (r.state == pmac_pkg::PMAC_ST_DONE && !write_in) begin
			next_r.state = pmac_pkg::PMAC_ST_IDLE;
		end
		next_r.busy = (next_r.state == pmac_pkg::PMAC_ST_BUSY);
		if (read_in) begin
			case (addr_in)
				pmac_pkg::ADDR_UNSIGNED_PRODUCT,
				pmac_pkg::ADDR_SIGNED_PRODUCT,
				pmac_pkg::ADDR_UNSIGNED_ACCUM,
				pmac_pkg::ADDR_SIGNED_ACCUM:   next_r.rdata = r.first_operand;
				pmac_pkg::ADDR_SECOND_OPERAND: next_r.rdata = r.second_operand;
				// Bypass so a read on the landing edge already sees the result
				// Indirect reads one cycle early would see the old word
				pmac_pkg::ADDR_RESULT_LOW:     next_r.rdata = next_r.result_low;
				pmac_pkg::ADDR_RESULT_HIGH:    next_r.rdata = next_r.result_high;
				pmac_pkg::ADDR_RESULT_EXT:     next_r.rdata = next_r.result_ext;
				default:                       next_r.rdata = pmac_pkg::WORD_RESET;
			endcase
		end else begin
			next_r.rdata = pmac_pkg::WORD_RESET;
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign rdata_out = r.rdata;
	assign busy_out  = r.busy;

endmodule : pmac_multiplier

// *** pmac_checker.sv ***
// Port checker for the multiply-accumulate peripheral.
// Sees only top-level ports; bound below.
`timescale 1ns/1ns
module pmac_checker (
	input wire logic        clk_in,
	input wire logic        rst_n_in,
	input wire logic [8:0]  addr_in,
	input wire logic        write_in,
	input wire logic        read_in,
	input wire logic        byte_in,
	input wire logic [15:0] wdata_in,
	input wire logic [15:0] rdata_out,
	input wire logic        busy_out
);
	// ****
	// Helpers
	// ****
	logic [8:0] mode_addr;
	wire        trig = write_in && addr_in == 9'h138;
	wire        op1  = write_in && addr_in[8:3] == 6'h26;
	always_ff @(posedge clk_in or negedge rst_n_in)
		if (!rst_n_in) mode_addr <= 9'h130;
		else if (op1) mode_addr <= addr_in;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	// Extension read right at the documented latency
	sequence ext_read(c);
		trig && c ##1 (!write_in)[*2] ##1 read_in && addr_in == 9'h13e;
	endsequence
	AST_OP1_IDLE: assert property (op1 && !busy_out && !$past(trig) |=> !busy_out)
		else $error("operand one write started work");
	AST_BUSY_SET: assert property (trig |-> ##[1:2] busy_out)
		else $error("trigger did not start work");
	AST_BUSY_END: assert property (trig ##1 (!trig)[*4] |-> !busy_out)
		else $error("operation ran too long");
	AST_OP_WIDTH: assert property (trig && !byte_in ##1 read_in && addr_in == 9'h138
		|=> rdata_out == $past(wdata_in, 2)) else $error("operand two lost bits");
	AST_BYTE_CLR: assert property (trig && byte_in ##1 read_in && addr_in == 9'h138
		|=> rdata_out == ($past(wdata_in, 2) & 16'h00ff)) else $error("byte write kept top");
	AST_KEEP_OP1: assert property (op1 && !byte_in ##1 trig ##1 !write_in ##1 read_in &&
		addr_in[8:3] == 6'h26 |=> rdata_out == $past(wdata_in, 4)) else $error("operand lost");
	AST_UMPY_EXT: assert property (ext_read(mode_addr == 9'h130) |=> rdata_out == 16'h0000)
		else $error("extension not zero");
	AST_UMAC_EXT: assert property (ext_read(mode_addr == 9'h134) |=> rdata_out[15:1] == 15'h0)
		else $error("extension not a carry");
	AST_SIGN_EXT: assert property (ext_read(mode_addr[1]) |=> rdata_out == 16'h0000 ||
		rdata_out == 16'hffff) else $error("extension not a sign");
endmodule : pmac_checker
bind pmac_multiplier pmac_checker u_checker (.clk_in(clk_in), .rst_n_in(rst_n_in),
	.addr_in(addr_in), .write_in(write_in), .read_in(read_in), .byte_in(byte_in),
	.wdata_in(wdata_in), .rdata_out(rdata_out), .busy_out(busy_out));

// *** pmac_host.sv ***
// Host processor model: one bus request per clock.
// Assumes one calling process; requests change at falling edges.
`timescale 1ns/1ns
module pmac_host (
	input  wire logic        clk_in,
	output logic      [8:0]  addr_out = 9'h0,
	output logic             write_out = 1'b0,
	output logic             read_out = 1'b0,
	output logic             byte_out = 1'b0,
	output logic      [15:0] wdata_out = 16'h0
);
	// Idle cycles scramble the lines; caller spaces result reads
	task automatic req(input logic [1:0] wr_rd, input logic [8:0] a, input logic bt,
		input logic [15:0] d);
		@(negedge clk_in);
		{write_out, read_out} = wr_rd;
		addr_out = wr_rd != 2'b00 ? a : ~addr_out;
		byte_out = bt;
		wdata_out = wr_rd[1] ? d : ~wdata_out;
	endtask : req
endmodule : pmac_host

// *** peripheral_multiply_accumulator_bench.sv ***
// Self-checking bench for the multiply-accumulate peripheral.
// Assumes the host model and the bound checker.
`timescale 1ns/1ns
module peripheral_multiply_accumulator_bench;
	logic        clk_in = 1'b0, rst_n_in = 1'b0, wr, rd, bt, busy, rd_seen = 1'b0;
	logic [8:0]  addr, mode = 9'h130;
	logic [15:0] wd, rdata, e, ext, a, b, r, exp_q[$];
	logic [31:0] acc = 32'h0;
	int          failures = 0, samples_checked = 0, seed = 33;
	initial begin
		forever #5 clk_in = ~clk_in;
	end
	pmac_host u_host (.clk_in(clk_in), .addr_out(addr), .write_out(wr), .read_out(rd),
		.byte_out(bt), .wdata_out(wd));
	pmac_multiplier u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr),
		.write_in(wr), .read_in(rd), .byte_in(bt), .wdata_in(wd), .rdata_out(rdata),
		.busy_out(busy));
	// ****
	// Result watcher
	// ****
	always @(posedge clk_in) rd_seen <= rd;
	always @(negedge clk_in) if (rd_seen) begin
		samples_checked++;
		e = exp_q.pop_front();
		if (rdata !== e) begin
			failures++;
			$display("unexpected rdata_out: expected %h seen %h", e, rdata);
		end
	end
	task automatic rd_chk(input logic [8:0] ra, input logic [15:0] v);
		exp_q.push_back(v);
		u_host.req(2'b01, ra, 1'b0, 16'(r ^ 16'h5a5a));
	endtask : rd_chk
	// Fixed operands force a signed accumulate overflow
	task automatic run(input bit w1, input logic [8:0] m, input logic bb, input bit fx);
		logic [32:0] s;
		logic signed [31:0] p;
		if (w1) begin
			mode = m;
			r = fx ? 16'h7fff : 16'($random(seed));
			u_host.req(2'b10, m, bb, r);
			a = bb ? {8'h00, r[7:0]} : r;
		end
		r = fx ? 16'h7fff : 16'($random(seed));
		b = bb ? {8'h00, r[7:0]} : r;
		u_host.req(2'b10, 9'h138, bb, r);
		if (mode[1]) p = $signed(a) * $signed(b);
		else p = a * b;
		s = mode[2] ? {1'b0, acc} + {1'b0, p} : {1'b0, p};
		acc = s[31:0];
		ext = mode[1] ? {16{s[31]}} : {15'h0, s[32]};
		rd_chk(9'h138, b);
		rd_chk(mode, a);
		rd_chk(9'h13e, ext);
		rd_chk(9'h13a, acc[15:0]);
		rd_chk(9'h13c, acc[31:16]);
	endtask : run
	task automatic results;
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : results
	initial begin
		repeat (12) @(posedge clk_in);
		@(negedge clk_in) rst_n_in = 1'b1;
		for (int i = 0; i < 16; i++) begin
			run(i % 3 != 2, 9'h130 + 9'(2 * (i % 4)), i > 11, 1'b0);
			$display("test %0d done", i);
		end
		u_host.req(2'b10, 9'h13a, 1'b0, 16'hffff);
		u_host.req(2'b10, 9'h13c, 1'b0, 16'h7fff);
		acc = 32'h7fffffff;
		run(1'b1, 9'h136, 1'b0, 1'b1);
		u_host.req(2'b10, 9'h13e, 1'b0, 16'h1234);
		rd_chk(9'h13e, ext);
		rd_chk(9'h140, 16'h0000);
		u_host.req(2'b00, 9'h0, 1'b0, 16'h0);
		repeat (3) @(negedge clk_in);
		$display("test refusals done");
		results();
	end
	initial begin
		repeat (20000) @(posedge clk_in);
		failures++;
		results();
	end
endmodule : peripheral_multiply_accumulator_bench
